// >>> rtl/sigs_group_status.sv
// Summary of operation
// R1: Bit is 1 when channel interrupt raised
// R2: Only enabled channel interrupts can set bits
// R3: Group0 bit31 unit0 ch0 down to unit3 ch7
// R4: Group1 bit31 unit4 ch0 down to unit6 ch7
// R5: Group1 bits 7..0 always read zero
// R6: Software writes zero to group1 low byte
// R7: Read-only, reset zero, follows submodule flags
`timescale 1ns/100ps
`include "sigs_regs.svh"
module sigs_group_status
  import sigs_pkg::*;
#(
  parameter int UNITS0 = 4,
  parameter int UNITS1 = 3,
  parameter int CHANS = 8
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic SRST,
  // Per-channel raw flags and enables, channel c of the group's u-th unit (from 0) at index u*8+c
  input wire logic [UNITS0*CHANS-1:0] SEQ_LO_IRQ_FLAG,
  input wire logic [UNITS0*CHANS-1:0] SEQ_LO_IRQ_EN,
  input wire logic [UNITS1*CHANS-1:0] SEQ_HI_IRQ_FLAG,
  input wire logic [UNITS1*CHANS-1:0] SEQ_HI_IRQ_EN,
  // Register port
  input wire logic [`SIGS_ADDR_W-1:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  // Interrupt
  output logic IRQ
);
  // Flag vector widths of the two groups
  localparam int LO_W = UNITS0*CHANS;
  localparam int HI_W = UNITS1*CHANS;

  // Gated, reordered flags; each unit owns one byte, the group's first unit (0 or 4) on top
  logic [LO_W-1:0] lanes0;
  logic [HI_W-1:0] lanes1;

  // Images that software reads
  sigs_word_t group0;
  sigs_word_t group1;

  // Images one cycle back, for the nonzero-edge events
  sigs_word_t group0_q;
  sigs_word_t group1_q;

  // Event status, its mask and their next values
  sigs_ev_t pend;
  sigs_ev_t evmask;
  sigs_ev_t set_pend;
  sigs_ev_t clr_pend;
  sigs_ev_t next_pend;
  sigs_ev_t next_evmask;

  // Next values of the registered outputs
  sigs_word_t next_rdata;
  logic next_irq;

  genvar g;
  generate
    // Units 0 to 3 fill group 0 from the top byte down
    for (g = 0; g < UNITS0; g++) begin : gen_lo
      wire [CHANS-1:0] raw = SEQ_LO_IRQ_FLAG[g*CHANS +: CHANS];
      wire [CHANS-1:0] en = SEQ_LO_IRQ_EN[g*CHANS +: CHANS];
      sigs_unit_lane #(.CHANS(CHANS)) u_lane (
        .CLK(CLK),
        .SRST(SRST),
        .raw(raw), // R1
        .en(en), // R2
        .lane(lanes0[(UNITS0-1-g)*CHANS +: CHANS]) // R3
      );
    end

    // Units 4 to 6 fill group 1 above the reserved byte
    for (g = 0; g < UNITS1; g++) begin : gen_hi
      wire [CHANS-1:0] raw = SEQ_HI_IRQ_FLAG[g*CHANS +: CHANS];
      wire [CHANS-1:0] en = SEQ_HI_IRQ_EN[g*CHANS +: CHANS];
      sigs_unit_lane #(.CHANS(CHANS)) u_lane (
        .CLK(CLK),
        .SRST(SRST),
        .raw(raw), // R1
        .en(en), // R2
        .lane(lanes1[(UNITS1-1-g)*CHANS +: CHANS]) // R4
      );
    end
  endgenerate

  assign group0 = lanes0; // R3

  // Low byte is tied off, not stored, so it can never read back nonzero
  assign group1 = {lanes1, `SIGS_RESV_W'h00}; // R5

  // Group bits follow the gated flags rather than hold them: a bit
  // clears one cycle after its unit drops the flag or the enable, since
  // clearing belongs to the unit and a second sticky copy here could
  // disagree with it
  // R7

  // A group is busy while any of its channels reports
  wire any0 = |group0;
  wire any1 = |group1;
  wire any0_q = |group0_q;
  wire any1_q = |group1_q;

  // Events: a group turning nonzero since the last cycle
  wire rise0 = any0 & ~any0_q;
  wire rise1 = any1 & ~any1_q;
  assign set_pend = {rise1, rise0};

  // Address decode
  wire sel_g0 = (ADDR == `SIGS_OFS_GROUP0);
  wire sel_g1 = (ADDR == `SIGS_OFS_GROUP1);
  wire sel_mask = (ADDR == `SIGS_OFS_MASK);
  wire sel_pend = (ADDR == `SIGS_OFS_PEND);

  // Group registers ignore writes; only mask and pending are writable
  wire wr_mask = WR & sel_mask; // R7
  wire wr_pend = WR & sel_pend; // R7
  wire [1:0] wdata_ev = WDATA[1:0];
  assign clr_pend = wr_pend ? wdata_ev : 2'h0;

  // Set beats clear when both land in one cycle, so an event that
  // arrives while software clears an older one is never lost
  assign next_pend = (pend & ~clr_pend) | set_pend;
  assign next_evmask = wr_mask ? wdata_ev : evmask;

  // Read select as an AND-OR of one-hot selects; unmapped offsets read 0
  wire [31:0] mask_word = {30'h0, evmask};
  wire [31:0] pend_word = {30'h0, pend};
  wire [31:0] rd_g0 = sel_g0 ? group0 : 32'h00000000;
  wire [31:0] rd_g1 = sel_g1 ? group1 : 32'h00000000;
  wire [31:0] rd_mask = sel_mask ? mask_word : 32'h00000000;
  wire [31:0] rd_pend = sel_pend ? pend_word : 32'h00000000;
  wire [31:0] rd_mux = rd_g0 | rd_g1 | rd_mask | rd_pend;

  // Data stand only in the cycle after a read strobe
  assign next_rdata = RD ? rd_mux : 32'h00000000;

  // Built from the values being loaded, so the output never lags the
  // pending and mask bits that software reads back
  assign next_irq = |(next_pend & next_evmask);

  always_ff @(posedge CLK) begin
    if (SRST) begin
      group0_q <= `SIGS_RST_GROUP; // R7
    end else begin
      group0_q <= group0;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      group1_q <= `SIGS_RST_GROUP; // R7
    end else begin
      group1_q <= group1;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      pend <= `SIGS_RST_EVMASK;
    end else begin
      pend <= next_pend;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      evmask <= `SIGS_RST_EVMASK;
    end else begin
      evmask <= next_evmask;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      RDATA <= 32'h00000000;
    end else begin
      RDATA <= next_rdata;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      IRQ <= 1'h0;
    end else begin
      IRQ <= next_irq;
    end
  end
endmodule

// >>> rtl/sigs_pkg.sv
package sigs_pkg;
  typedef logic [31:0] sigs_word_t;
  typedef logic [7:0] sigs_unit_t;
  typedef logic [1:0] sigs_ev_t;
endpackage

// >>> rtl/sigs_regs.svh
`ifndef SIGS_REGS_SVH
`define SIGS_REGS_SVH

`define SIGS_ADDR_W 4
`define SIGS_OFS_GROUP0 4'h0
`define SIGS_OFS_GROUP1 4'h4
`define SIGS_OFS_MASK 4'h8
`define SIGS_OFS_PEND 4'hC
`define SIGS_RESV_LSB 0
`define SIGS_RESV_MSB 7
`define SIGS_RESV_W 8
`define SIGS_RST_GROUP 32'h00000000
`define SIGS_RST_EVMASK 2'h0
`define SIGS_EV_GROUP0 0
`define SIGS_EV_GROUP1 1

`endif

// >>> rtl/sigs_unit_lane.sv
`timescale 1ns/100ps
`include "sigs_regs.svh"
// One sequencer unit: eight raw flags gated by their enables, bit-reversed
// so channel 0 lands in the most significant position of the byte.
module sigs_unit_lane
  import sigs_pkg::*;
#(
  parameter int CHANS = 8
) (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic [CHANS-1:0] raw,
  input wire logic [CHANS-1:0] en,
  output logic [CHANS-1:0] lane
);
  logic [CHANS-1:0] next_lane;

  always_comb begin
    for (int i = 0; i < CHANS; i++) begin
      next_lane[CHANS-1-i] = raw[i] & en[i];
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      lane <= '0;
    end else begin
      lane <= next_lane;
    end
  end
endmodule

// >>> verif/sigs_group_status_properties.sv
`timescale 1ns/100ps
module sigs_chk (
  input wire logic CLK, SRST, RD, IRQ,
  input wire logic [31:0] SEQ_LO_IRQ_FLAG, SEQ_LO_IRQ_EN, RDATA,
  input wire logic [23:0] SEQ_HI_IRQ_FLAG, SEQ_HI_IRQ_EN,
  input wire logic [3:0] ADDR
);
  wire logic [31:0] lo = SEQ_LO_IRQ_FLAG & SEQ_LO_IRQ_EN;
  wire logic [23:0] hi = SEQ_HI_IRQ_FLAG & SEQ_HI_IRQ_EN;
  // Channel 0 of the lowest unit belongs at the top of the word
  wire logic [31:0] lo_rev = {<<{lo}};
  wire logic [23:0] hi_rev = {<<{hi}};
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);
  property p_grp0;
    $past(RD) && $past(ADDR) == 4'h0 |-> RDATA == $past(lo_rev, 2);
  endproperty
  a_grp0: assert property (p_grp0) else $error("group0 bad");
  property p_grp1;
    $past(RD) && $past(ADDR) == 4'h4 |-> RDATA[31:8] == $past(hi_rev, 2);
  endproperty
  a_grp1: assert property (p_grp1) else $error("group1 bad");
  property p_resv;
    $past(RD) && $past(ADDR) == 4'h4 |-> RDATA[7:0] == 8'h0;
  endproperty
  a_resv: assert property (p_resv) else $error("low byte set");
  property p_rst;
    $past(SRST) |-> RDATA == 32'h0 && !IRQ;
  endproperty
  a_rst: assert property (p_rst) else $error("not clear");
  property p_dis0;
    $past(RD) && $past(ADDR) == 4'h0 && $past(SEQ_LO_IRQ_EN, 2) == 32'h0
      |-> RDATA == 32'h0;
  endproperty
  a_dis0: assert property (p_dis0) else $error("group0 disabled set");
  property p_dis1;
    $past(RD) && $past(ADDR) == 4'h4 && $past(SEQ_HI_IRQ_EN, 2) == 24'h0
      |-> RDATA == 32'h0;
  endproperty
  a_dis1: assert property (p_dis1) else $error("group1 disabled set");
  property p_idle;
    !$past(RD) |-> RDATA == 32'h0;
  endproperty
  a_idle: assert property (p_idle) else $error("data without read");
endmodule
bind sigs_group_status sigs_chk u_chk (.*);

// >>> verif/sigs_group_status_tb.sv
`timescale 1ns/100ps
module sigs_group_status_tb;
  logic CLK = 0, SRST = 1, WR = 0, RD = 0, IRQ;
  logic [31:0] LF = 0, LE = 0, WDATA = 0, RDATA;
  logic [23:0] HF = 0, HE = 0;
  logic [3:0] ADDR = 0;
  int errors = 0, checks_done = 0;
  // Edge channels of each group, all flags with enables off, then all flags with only the last unit of each group enabled
  logic [31:0] rows [3][6] = '{
    '{32'h1, '1, 32'h1, '1, 32'h80000000, 32'h80000000},
    '{'1, 32'h0, '1, 32'h0, 32'h0, 32'h0},
    '{'1, 32'hFF000000, '1, 32'hFF0000, 32'hFF, 32'hFF00}};
  sigs_group_status u_dut (.CLK, .SRST, .SEQ_LO_IRQ_FLAG(LF),
    .SEQ_LO_IRQ_EN(LE), .SEQ_HI_IRQ_FLAG(HF), .SEQ_HI_IRQ_EN(HE),
    .ADDR, .WDATA, .WR, .RD, .RDATA, .IRQ);
  initial forever #12.5 CLK = ~CLK;
  task summarize;
    if (errors == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(string n, logic [31:0] s, e);
    checks_done++;
    errors += (s !== e);
    if (s !== e) $display("CHECK FAILED %s exp %h got %h", n, e, s);
  endtask
  task wr(logic [3:0] a, logic [31:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1;
    @(posedge CLK);
    WR <= 0;
  endtask
  task rd(logic [3:0] a, logic [31:0] e, string n);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1;
    @(posedge CLK);
    RD <= 0;
    #1 chk(n, RDATA, e);
  endtask
  initial begin
    repeat (5) @(posedge CLK);
    SRST <= 0;
    rd(4'h0, 32'h0, "grp0 reset");
    rd(4'h2, 32'h0, "unmapped");
    foreach (rows[i]) begin
      @(posedge CLK);
      LF <= rows[i][0];
      LE <= rows[i][1];
      HF <= rows[i][2][23:0];
      HE <= rows[i][3][23:0];
      rd(4'h0, rows[i][4], "grp0");
      rd(4'h4, rows[i][5], "grp1");
    end
    wr(4'h0, '1);
    wr(4'h4, 32'hFFFFFF00);
    rd(4'h0, rows[2][4], "grp0 ro");
    rd(4'h4, rows[2][5], "grp1 ro");
    @(posedge CLK);
    LF <= 32'h0;
    wr(4'h8, 32'h0);
    wr(4'hC, 32'h3);
    LF <= 32'h1;
    LE <= '1;
    repeat (3) @(posedge CLK);
    #1 chk("irq masked", IRQ, 32'h0);
    wr(4'h8, 32'h1);
    repeat (2) @(posedge CLK);
    #1 chk("irq", IRQ, 32'h1);
    rd(4'h8, 32'h1, "mask");
    rd(4'hC, 32'h1, "pend");
    wr(4'hC, 32'h1);
    repeat (2) @(posedge CLK);
    #1 chk("irq clear", IRQ, 32'h0);
    rd(4'hC, 32'h0, "pend clear");
    // Drop and raise the flag again so the output is high at reset
    @(posedge CLK);
    LF <= 32'h0;
    @(posedge CLK);
    LF <= 32'h1;
    repeat (3) @(posedge CLK);
    #1 chk("irq again", IRQ, 32'h1);
    @(posedge CLK);
    SRST <= 1;
    repeat (2) @(posedge CLK);
    SRST <= 0;
    #1 chk("rst irq", IRQ, 32'h0);
    chk("rst rdata", RDATA, 32'h0);
    rd(4'h8, 32'h0, "rst mask");
    rd(4'h0, 32'h80000000, "rst follow");
    chk("rst irq masked", IRQ, 32'h0);
    summarize;
  end
  // Whole run is under a hundred cycles
  initial begin
    #50us;
    errors++;
    summarize;
  end
endmodule
